//--- include/tsa_pkg.sv
// Shared constants and types for the two-channel serial audio port.
package tsa_pkg;
   localparam int unsigned CLK_HZ = 100000000;
   localparam int unsigned WORD_MAX = 24;
   localparam int unsigned SUB_BITS = 32;
   localparam int unsigned BCLK_PER_FRAME = 64;
   localparam int unsigned MCLK_PER_FRAME = 256;
   localparam int unsigned MSB_SLOT = 1;
   localparam logic [4:0] MSB_SLOT_5 = 5'h01;
   localparam logic [4:0] SLOT_LAST = 5'h1f;
   localparam logic [4:0] WIDTH_DEF = 5'h18;
   localparam logic [4:0] WIDTH_MIN = 5'h08;
   localparam logic [7:0] RATE_DIV_DEF = 8'h08;
   localparam logic [23:0] ZERO_WORD = 24'h000000;
   localparam logic [4:0] ZERO_CNT = 5'h00;
   localparam logic [7:0] ZERO_DIV = 8'h00;
   typedef enum logic {CH_A, CH_B} tsa_chan_t;
   typedef enum logic [1:0] {FMT_SERIAL, FMT_PRO, FMT_CONSUMER} tsa_fmt_t;
endpackage

//--- hw/tsa_sync.sv
// Two-flip-flop synchroniser with edge detection on the settled copy.
`timescale 1ns/1ps
module tsa_sync (
   // Clock and reset.
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // Asynchronous level in, settled level and edges out.
   input wire logic async_in,
   output logic level_out,
   output logic rise_out,
   output logic fall_out
);
   typedef struct packed {
      logic meta;
      logic settled;
      logic prev;
   } tsa_sync_state_t;
   tsa_sync_state_t st, next_st;

   // The first stage feeds only the second; edges are taken from stage two.
   always_comb begin
      next_st = st;
      next_st.meta = async_in;
      next_st.settled = st.meta;
      next_st.prev = st.settled;
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level_out = st.settled;
   assign rise_out = st.settled & ~st.prev;
   assign fall_out = ~st.settled & st.prev;
endmodule // tsa_sync

//--- hw/tsa_clkgen.sv
// Divider that makes the 256x master clock and the 64x bit clock enables.
`timescale 1ns/1ps
module tsa_clkgen (
   // Clock and reset.
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // Half period of the master clock in system cycles.
   input wire logic [7:0] half_div_in,
   // Master clock level and bit clock edge enables.
   output logic mclk_out,
   output logic bclk_out,
   output logic bclk_rise_out,
   output logic bclk_fall_out
);
   typedef struct packed {
      logic [7:0] div;
      logic [2:0] phase;
      logic mclk;
      logic bclk;
      logic rise;
      logic fall;
   } tsa_clkgen_state_t;
   tsa_clkgen_state_t st, next_st;

   // Eight master half periods make one bit period, hence 256 over 64.
   always_comb begin
      next_st = st;
      next_st.rise = 1'b0;
      next_st.fall = 1'b0;
      if (st.div + 8'h01 >= half_div_in) begin
         next_st.div = tsa_pkg::ZERO_DIV;
         next_st.mclk = ~st.mclk;
         next_st.phase = st.phase + 3'h1;
         if (st.phase == 3'h3) begin
            next_st.bclk = 1'b0;
            next_st.fall = 1'b1;
         end else if (st.phase == 3'h7) begin
            next_st.bclk = 1'b1;
            next_st.rise = 1'b1;
         end
      end else begin
         next_st.div = st.div + 8'h01;
      end
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign mclk_out = st.mclk;
   assign bclk_out = st.bclk;
   assign bclk_rise_out = st.rise;
   assign bclk_fall_out = st.fall;
endmodule // tsa_clkgen

//--- hw/tsa_port.sv
// Two-channel serial audio port: receiver, transmitter and clock outputs.
`timescale 1ns/1ps
// Overview of operation
// [R1] Source changes data and sync on rising edge.
// [R2] Input data sampled on bit clock falling edge.
// [R3] MSB in second bit slot of sub-frame.
// [R4] Input bit clock is 64x frame rate.
// [R5] Input sync low for A, high for B.
// [R6] Input frame rate within 27 to 54 kHz.
// [R7] Optional input master clock is 256x rate.
// [R8] Input always two-channel, word-wide sync.
// [R9] Output words up to 24 bits, width set.
// [R10] Output MSB one bit after sync edge.
// [R11] Output bit clock is 64x sample rate.
// [R12] Output data changes on bit clock rise.
// [R13] Output sync low for A, high for B.
// [R14] Serial port and digital interface share hardware.
// [R15] Master clock output at 256x sample rate.
// [R16] Transmit frame sync follows reference when slaved.
// [R17] Zero beyond width; ignore input past bit 24.
// [R18] Parallel word at sync edge; preload output word.
module tsa_port (
   // Clock and reset.
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // Configuration.
   input wire logic [1:0] in_format_in,
   input wire logic [1:0] out_format_in,
   input wire logic [4:0] out_width_in,
   input wire logic [7:0] rate_half_div_in,
   input wire logic ref_slave_in,
   input wire logic ref_sync_in,
   // Serial input pins.
   input wire logic ser_in_data_in,
   input wire logic ser_in_bclk_in,
   input wire logic ser_in_fsync_in,
   input wire logic ser_in_mclk_in,
   // Received words.
   output logic [23:0] rx_word_out,
   output logic rx_chan_b_out,
   output logic rx_valid_out,
   output logic rx_mclk_seen_out,
   // Words to send.
   input wire logic [23:0] tx_word_a_in,
   input wire logic [23:0] tx_word_b_in,
   output logic tx_take_out,
   // Serial output pins.
   output logic ser_out_data_out,
   output logic ser_out_bclk_out,
   output logic ser_out_fsync_out,
   output logic mclk_out,
   output logic tx_fsync_out
);
   typedef struct packed {
      logic [23:0] rx_shift;
      logic [4:0] rx_slot;
      logic rx_side;
      logic [23:0] rx_word;
      logic rx_chan_b;
      logic rx_valid;
      logic rx_mclk_seen;
      logic [23:0] tx_shift;
      logic [23:0] tx_next_a;
      logic [23:0] tx_next_b;
      logic [4:0] tx_slot;
      logic tx_side;
      logic tx_take;
      logic ser_data;
      logic ser_bclk;
      logic ser_fsync;
      logic mclk;
      logic tx_fsync;
   } tsa_port_state_t;
   tsa_port_state_t st, next_st;

   logic bclk_lvl, bclk_rise, bclk_fall;
   logic fs_lvl, dat_lvl, mck_rise, ref_lvl;
   logic gen_mclk, gen_bclk, gen_rise, gen_fall;
   logic in_serial, out_serial;

   // The bit clock and pins are sampled by the system clock, so the input
   // bit clock must stay well below a quarter of the system rate.
   tsa_sync u_bclk (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .async_in(ser_in_bclk_in),
      .level_out(bclk_lvl),
      .rise_out(bclk_rise),
      .fall_out(bclk_fall)
   );
   tsa_sync u_fsync (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .async_in(ser_in_fsync_in),
      .level_out(fs_lvl),
      .rise_out(),
      .fall_out()
   );
   tsa_sync u_data (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .async_in(ser_in_data_in),
      .level_out(dat_lvl),
      .rise_out(),
      .fall_out()
   );
   tsa_sync u_mclk (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .async_in(ser_in_mclk_in),
      .level_out(),
      .rise_out(mck_rise),
      .fall_out()
   );
   tsa_sync u_ref (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .async_in(ref_sync_in),
      .level_out(ref_lvl),
      .rise_out(),
      .fall_out()
   );

   tsa_clkgen u_gen (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .half_div_in(rate_half_div_in),
      .mclk_out(gen_mclk),
      .bclk_out(gen_bclk),
      .bclk_rise_out(gen_rise),
      .bclk_fall_out(gen_fall)
   );

   // Only one of the two interfaces owns the shared hardware at a time.
   assign in_serial = (in_format_in == 2'(tsa_pkg::FMT_SERIAL)); // see [R14]
   assign out_serial = (out_format_in == 2'(tsa_pkg::FMT_SERIAL)); // see [R14]

   function automatic logic [23:0] tsa_mask(input logic [23:0] w, input logic [4:0] width);
      logic [23:0] m;
      m = ~tsa_pkg::ZERO_WORD;
      if (width < 5'(tsa_pkg::WORD_MAX)) begin
         m = ~(m >> width);
      end
      return w & m;
   endfunction

   function automatic logic [4:0] tsa_width(input logic [4:0] w);
      logic [4:0] r;
      r = w;
      if (w > 5'(tsa_pkg::WORD_MAX)) begin
         r = 5'(tsa_pkg::WORD_MAX);
      end else if (w < tsa_pkg::WIDTH_MIN) begin
         r = tsa_pkg::WIDTH_MIN;
      end
      return r;
   endfunction

   localparam logic [4:0] SLOT_LOAD = 5'h10;

   always_comb begin
      next_st = st;
      next_st.rx_valid = 1'b0;
      next_st.tx_take = 1'b0;
      if (mck_rise) begin
         next_st.rx_mclk_seen = 1'b1; // see [R7]
      end
      // Receiver: sample on falling bit clock edge; the sync level names the
      // channel and always spans a whole sub-frame.
      if (in_serial && bclk_fall) begin // see [R2] [R1]
         if (fs_lvl != st.rx_side) begin // see [R8] [R5]
            next_st.rx_word = st.rx_shift;
            next_st.rx_chan_b = st.rx_side; // see [R18]
            next_st.rx_valid = 1'b1;
            next_st.rx_side = fs_lvl;
            next_st.rx_slot = tsa_pkg::ZERO_CNT; // see [R3]
            next_st.rx_shift = tsa_pkg::ZERO_WORD;
         end else begin
            if (st.rx_slot != tsa_pkg::SLOT_LAST) begin
               next_st.rx_slot = st.rx_slot + 5'h01;
            end
            // Slot 0 carries no data; slots past the 24th are dropped.
            if (st.rx_slot + 5'h01 >= tsa_pkg::MSB_SLOT_5 &&
                st.rx_slot + 5'h01 <= 5'(tsa_pkg::WORD_MAX)) begin // see [R3] [R17] [R4]
               next_st.rx_shift[5'(tsa_pkg::WORD_MAX) - (st.rx_slot + 5'h01)] = dat_lvl;
            end
         end
      end
      // Transmitter: 32 slots per channel; everything moves on the rising edge.
      // The frame counter runs in every format so the transmit sync keeps the sample rate.
      if (gen_rise) begin // see [R11] [R12]
         next_st.tx_slot = st.tx_slot + 5'h01;
         next_st.ser_data = 1'b0;
         if (st.tx_slot == tsa_pkg::SLOT_LAST) begin
            next_st.tx_side = ~st.tx_side; // see [R13]
            next_st.tx_shift = st.tx_side ? tsa_mask(st.tx_next_a, tsa_width(out_width_in))
                                          : tsa_mask(st.tx_next_b, tsa_width(out_width_in)); // see [R9] [R17]
         end else if (st.tx_slot + 5'h01 >= tsa_pkg::MSB_SLOT_5 &&
                      st.tx_slot < 5'(tsa_pkg::WORD_MAX)) begin
            next_st.ser_data = st.tx_shift[23]; // see [R10] [R17]
            next_st.tx_shift = {st.tx_shift[22:0], 1'b0};
         end
         // Words for the next frame are taken well before the first MSB.
         if (out_serial && st.tx_slot == SLOT_LOAD && st.tx_side) begin // see [R18]
            next_st.tx_next_a = tx_word_a_in;
            next_st.tx_next_b = tx_word_b_in;
            next_st.tx_take = 1'b1;
         end
      end
      if (out_serial) begin
         next_st.ser_bclk = gen_bclk; // see [R11]
         next_st.ser_fsync = next_st.tx_side; // see [R13]
      end else begin
         next_st.ser_bclk = 1'b0;
         next_st.ser_data = 1'b0;
         next_st.ser_fsync = 1'b0; // see [R14]
      end
      next_st.mclk = gen_mclk; // see [R15]
      // The frame sync marker follows the reference when the rate is slaved.
      next_st.tx_fsync = ref_slave_in ? ref_lvl : st.tx_side; // see [R16]
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rx_word_out = st.rx_word;
   assign rx_chan_b_out = st.rx_chan_b;
   assign rx_valid_out = st.rx_valid;
   assign rx_mclk_seen_out = st.rx_mclk_seen;
   assign tx_take_out = st.tx_take;
   assign ser_out_data_out = st.ser_data;
   assign ser_out_bclk_out = st.ser_bclk;
   assign ser_out_fsync_out = st.ser_fsync;
   assign mclk_out = st.mclk;
   assign tx_fsync_out = st.tx_fsync;
endmodule // tsa_port

//--- verif/tsa_port_props.sv
// Checker for the serial audio port pins.
`timescale 1ns/1ps
module tsa_port_props (
   // Clock, reset and setup.
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic [1:0] in_format_in,
   input wire logic [1:0] out_format_in,
   input wire logic [7:0] rate_half_div_in,
   input wire logic ref_slave_in,
   input wire logic ref_sync_in,
   // Outputs watched.
   input wire logic rx_valid_out,
   input wire logic tx_take_out,
   input wire logic ser_out_data_out,
   input wire logic ser_out_bclk_out,
   input wire logic ser_out_fsync_out,
   input wire logic tx_fsync_out
);
   logic [15:0] gap;
   logic seen;
   wire logic off = out_format_in != 2'h0;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   // The first sync edge after reset ends no whole sub-frame, so it is not timed.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         gap <= 16'h0000;
         seen <= 1'b0;
      end else begin
         gap <= (off || $changed(ser_out_fsync_out)) ? 16'h0000 : gap + 16'h0001;
         seen <= !off && (seen || $changed(ser_out_fsync_out));
      end
   end
   sequence s_fs_edge;
      $changed(ser_out_fsync_out);
   endsequence
   sequence s_bit_rise;
      $rose(ser_out_bclk_out);
   endsequence
   property p_data_on_rise;
      disable iff (!reset_n_in || off) $changed(ser_out_data_out) |-> s_bit_rise;
   endproperty
   property p_sync_on_rise;
      disable iff (!reset_n_in || off) s_fs_edge |-> s_bit_rise;
   endproperty
   property p_slot0_zero;
      disable iff (!reset_n_in || off) s_fs_edge |-> !ser_out_data_out;
   endproperty
   property p_frame_len;
      disable iff (!reset_n_in || off)
         seen && $changed(ser_out_fsync_out) |-> gap == {rate_half_div_in, 8'h00} - 16'h0001;
   endproperty
   property p_rx_pulse;
      rx_valid_out |=> !rx_valid_out;
   endproperty
   property p_take_b;
      tx_take_out |-> ser_out_fsync_out ##1 !tx_take_out;
   endproperty
   property p_rx_idle;
      (in_format_in != 2'h0) [*4] |-> !rx_valid_out;
   endproperty
   property p_tx_idle;
      (out_format_in != 2'h0) [*4] |-> !(ser_out_data_out || ser_out_bclk_out || ser_out_fsync_out);
   endproperty
   property p_ref_follow;
      ref_slave_in && $changed(ref_sync_in) |-> ##[1:6] tx_fsync_out == ref_sync_in;
   endproperty
   a_data_on_rise: assert property (p_data_on_rise) else $error("data moved off a clock rise");
   a_sync_on_rise: assert property (p_sync_on_rise) else $error("sync moved off a clock rise");
   a_slot0_zero: assert property (p_slot0_zero) else $error("data in sync slot");
   a_frame_len: assert property (p_frame_len) else $error("sub-frame length wrong");
   a_rx_pulse: assert property (p_rx_pulse) else $error("valid too long");
   a_take_b: assert property (p_take_b) else $error("take outside channel B");
   a_rx_idle: assert property (p_rx_idle) else $error("receiver active in other format");
   a_tx_idle: assert property (p_tx_idle) else $error("sender active in other format");
   a_ref_follow: assert property (p_ref_follow) else $error("sync ignores reference");
endmodule // tsa_port_props
bind tsa_port tsa_port_props i_tsa_port_props (.sys_clk_in, .reset_n_in, .in_format_in, .out_format_in,
   .rate_half_div_in, .ref_slave_in, .ref_sync_in, .rx_valid_out, .tx_take_out, .ser_out_data_out,
   .ser_out_bclk_out, .ser_out_fsync_out, .tx_fsync_out);

//--- verif/tsa_src.sv
// Model of the user logic that feeds the serial input pins.
`timescale 1ns/1ps
module tsa_src (
   // Start request and words.
   input wire logic run_in,
   input wire logic [23:0] word_a_in,
   input wire logic [23:0] word_b_in,
   // Serial pins.
   output logic data_out,
   output logic bclk_out,
   output logic fsync_out,
   output logic mclk_out
);
   logic [4:0] sub;
   initial begin
      data_out = 1'b0;
      bclk_out = 1'b0;
      fsync_out = 1'b0;
      mclk_out = 1'b0;
   end
   // Four master clock periods per bit; it stands still while run_in is low.
   always #20 mclk_out = run_in ? ~mclk_out : 1'b0;
   always begin
      wait (run_in);
      // The frame rate here is far above the legal range to keep runs short; the receiver does not depend on it.
      for (int s = 0; s < 64; s++) begin
         sub = 5'(s);
         bclk_out = 1'b1;
         fsync_out = s >= 32;
         // Unused slots toggle, so a receiver that reads them shows it.
         data_out = (sub >= 5'h01 && sub <= 5'h18) ?
            (s < 32 ? word_a_in[24 - sub] : word_b_in[24 - sub]) : sub[0];
         #80;
         bclk_out = 1'b0;
         #80;
      end
      data_out = ~data_out;
   end
endmodule // tsa_src

//--- verif/tb.sv
// Self-checking bench for the two-channel serial audio port.
`timescale 1ns/1ps
module tb;
   logic sys_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [1:0] in_format_in = 2'h0;
   logic [1:0] out_format_in = 2'h0;
   logic [4:0] out_width_in = 5'h18;
   logic [7:0] rate_half_div_in = 8'h02;
   logic ref_slave_in = 1'b0;
   logic ref_sync_in = 1'b0;
   logic run = 1'b0;
   logic [23:0] src_a = 24'h000000;
   logic [23:0] src_b = 24'h000000;
   logic [23:0] tx_word_a_in = 24'h000000;
   logic [23:0] tx_word_b_in = 24'h000000;
   logic ser_in_data_in, ser_in_bclk_in, ser_in_fsync_in, ser_in_mclk_in;
   logic [23:0] rx_word_out;
   logic rx_chan_b_out, rx_valid_out, rx_mclk_seen_out, tx_take_out;
   logic ser_out_data_out, ser_out_bclk_out, ser_out_fsync_out, mclk_out, tx_fsync_out;
   int n_fail = 0;
   int n_compared = 0;
   tsa_src i_tsa_src (.run_in(run), .word_a_in(src_a), .word_b_in(src_b), .data_out(ser_in_data_in),
      .bclk_out(ser_in_bclk_in), .fsync_out(ser_in_fsync_in), .mclk_out(ser_in_mclk_in));
   tsa_port i_tsa_port (.sys_clk_in, .reset_n_in, .in_format_in, .out_format_in, .out_width_in,
      .rate_half_div_in, .ref_slave_in, .ref_sync_in, .ser_in_data_in, .ser_in_bclk_in, .ser_in_fsync_in,
      .ser_in_mclk_in, .rx_word_out, .rx_chan_b_out, .rx_valid_out, .rx_mclk_seen_out, .tx_word_a_in,
      .tx_word_b_in, .tx_take_out, .ser_out_data_out, .ser_out_bclk_out, .ser_out_fsync_out, .mclk_out,
      .tx_fsync_out);
   initial forever #5 sys_clk_in = ~sys_clk_in;
   task automatic print_verdict;
      if (n_fail == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Waits for valid (0), take (1), a sync edge (2) or a bit clock fall (3).
   task automatic wait_on(input int sel, input int lim);
      logic f0;
      logic b0;
      int k;
      f0 = ser_out_fsync_out;
      for (k = 0; k < lim; k++) begin
         b0 = ser_out_bclk_out;
         @(posedge sys_clk_in);
         #1;
         if (sel == 0 ? rx_valid_out : sel == 1 ? tx_take_out : sel == 2 ? ser_out_fsync_out != f0 :
             b0 && !ser_out_bclk_out) break;
      end
      if (k == lim) begin
         check(24'(sel), 24'hffffff);
         print_verdict();
      end
   endtask
   task automatic t_rx;
      src_a = 24'ha5c381;
      src_b = 24'h5a3c7e;
      check({23'h0, rx_mclk_seen_out}, 24'h000000);
      run = 1'b1;
      // The first sub-frame after reset has no sync edge to align to, so only its tag is judged.
      wait_on(0, 4000);
      check({23'h0, rx_chan_b_out}, 24'h000000);
      wait_on(0, 4000);
      check(rx_word_out, src_b);
      check({23'h0, rx_chan_b_out}, 24'h000001);
      wait_on(0, 4000);
      check(rx_word_out, src_a);
      check({23'h0, rx_chan_b_out}, 24'h000000);
      check({23'h0, rx_mclk_seen_out}, 24'h000001);
      run = 1'b0;
   endtask
   task automatic t_tx(input logic [4:0] w, input logic [4:0] eff, input logic [23:0] a, input logic [23:0] b);
      logic [23:0] got [2];
      logic [23:0] m;
      logic extra;
      int sub;
      out_width_in = w;
      tx_word_a_in = a;
      tx_word_b_in = b;
      m = 24'hffffff << (5'h18 - eff);
      got[0] = 24'h000000;
      got[1] = 24'h000000;
      extra = 1'b0;
      wait_on(1, 3000);
      wait_on(2, 3000);
      for (int i = 0; i < 64; i++) begin
         wait_on(3, 40);
         sub = i % 32;
         if (sub >= 1 && sub <= 24) got[i / 32][24 - sub] = ser_out_data_out;
         else extra = extra | ser_out_data_out;
         if (sub == 16) check({23'h0, ser_out_fsync_out}, 24'(i / 32));
      end
      check(got[0], a & m);
      check(got[1], b & m);
      check({23'h0, extra}, 24'h000000);
   endtask
   task automatic t_clk_ref;
      int n;
      logic p;
      n = 0;
      p = mclk_out;
      // One output frame at a divider of two lasts 1024 cycles.
      repeat (1024) begin
         @(posedge sys_clk_in);
         #1;
         n += int'(mclk_out && !p);
         p = mclk_out;
      end
      check(24'(n), 24'h000100);
      ref_slave_in = 1'b1;
      for (int i = 0; i < 4; i++) begin
         ref_sync_in = ~ref_sync_in;
         repeat (8) @(posedge sys_clk_in);
         #1;
         check({23'h0, tx_fsync_out}, {23'h0, ref_sync_in});
      end
   endtask
   task automatic t_fmt;
      int n;
      n = 0;
      in_format_in = 2'h1;
      out_format_in = 2'h1;
      run = 1'b1;
      repeat (1500) begin
         @(posedge sys_clk_in);
         #1;
         n += int'(rx_valid_out || ser_out_bclk_out || ser_out_data_out || ser_out_fsync_out);
      end
      check(24'(n), 24'h000000);
   endtask
   initial begin
      repeat (16) @(posedge sys_clk_in);
      #1;
      reset_n_in = 1'b1;
      t_rx();
      t_tx(5'h18, 5'h18, 24'hc35a96, 24'h3ca569);
      t_tx(5'h08, 5'h08, 24'hffffff, 24'h81ff7e);
      t_tx(5'h04, 5'h08, 24'h7fffff, 24'hf0f0f0);
      t_clk_ref();
      t_fmt();
      print_verdict();
   end
endmodule // tb
